// file: rtl/t16_map.svh
// t16_map.svh: offsets, field positions, reset values and fixed counts of the 16-bit timer.
// assumes: included by the timer core and the testbench; definitions only.
// How it works
// - counter, compares, capture 16-bit; controls 8-bit
// - each request shown as flag, gated by mask
// - no tick source selected keeps counter idle
// - both compare values compared with counter continuously
// - compare match sets its match flag
// - capture edge copies counter into capture value unless capture is the limit
// - compare A as limit gives no PWM output
// - compare A limit is double buffered, except in mode 4
// - capture value may serve as fixed limit
// - minimum means counter equals zero
// - maximum means counter equals all ones
// - limit from fixed values, compare A, capture
// - one 8-bit high-byte holding register
// - holding register shared by all 16-bit registers
// - low write loads held high and low together
// - low read copies high byte into holding register
// - high read returns holding register
// - compare reads bypass holding register
// - holding byte kept between low writes
// - tick from prescaler or external count pin
// - force bits in control A, mode bit3 in B
// - counter write beats clear or count
// - filter changes after four equal samples
`ifndef T16_MAP_SVH
`define T16_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define T16_OFS_CTL_A     8'h00
`define T16_OFS_CTL_B     8'h04
`define T16_OFS_CNT_LO    8'h08
`define T16_OFS_CNT_HI    8'h0c
`define T16_OFS_CMPA_LO   8'h10
`define T16_OFS_CMPA_HI   8'h14
`define T16_OFS_CMPB_LO   8'h18
`define T16_OFS_CMPB_HI   8'h1c
`define T16_OFS_CAP_LO    8'h20
`define T16_OFS_CAP_HI    8'h24
`define T16_OFS_FLAGS     8'h28
`define T16_OFS_MASK      8'h2c

// ************************************************************
// field positions
// ************************************************************
`define T16_A_WAVE0       0
`define T16_A_WAVE1       1
`define T16_A_FORCE_B     2
`define T16_A_FORCE_A     3
`define T16_A_CAP_SRC     4
`define T16_B_TICK_LSB    0
`define T16_B_WAVE2       3
`define T16_B_WAVE3       4
`define T16_B_CAP_EDGE    6
`define T16_B_FILTER      7
`define T16_F_OVF         0
`define T16_F_MATCH_B     1
`define T16_F_MATCH_A     2
`define T16_F_CAPTURE     3

// ************************************************************
// reset values and fixed counts
// ************************************************************
`define T16_RST_BYTE      8'h00
`define T16_RST_WORD      16'h0000
`define T16_BOTTOM        16'h0000
`define T16_MAX           16'hffff
`define T16_TOP_8BIT      16'h00ff
`define T16_TOP_9BIT      16'h01ff
`define T16_TOP_10BIT     16'h03ff
`define T16_PRE_W         10
`define T16_FILTER_LEN    4
`define T16_RESP_OKAY     2'b00
`define T16_RESP_SLVERR   2'b10

`endif

// file: rtl/t16_pkg.sv
// t16_pkg.sv: types shared by the 16-bit timer.
// assumes: nothing beyond the language.
package t16_pkg;
	typedef logic [15:0] t16_word_t;
	typedef logic [7:0]  t16_byte_t;

	typedef enum logic [2:0] {
		T16_TICK_NONE  = 3'b000,
		T16_TICK_DIV1  = 3'b001,
		T16_TICK_DIV8  = 3'b010,
		T16_TICK_DIV64 = 3'b011,
		T16_TICK_DIV256 = 3'b100,
		T16_TICK_DIV1K = 3'b101,
		T16_TICK_EXTF  = 3'b110,
		T16_TICK_EXTR  = 3'b111
	} t16_tick_e;

	typedef struct packed {
		logic [3:0] wave_mode;
		t16_tick_e  tick_source_select;
		logic       capture_edge_rise;
		logic       capture_filter_enable;
		logic       capture_from_comparator;
	} t16_ctl_s;
endpackage

// file: rtl/t16_core.sv
// t16_core.sv: 16-bit timer/counter with byte access through a shared high-byte register.
// assumes: an AXI4-Lite master on clk; pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "t16_map.svh"

module t16_core import t16_pkg::*; #(
	parameter int PRE_W = `T16_PRE_W
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output      logic        wready,
	output      logic [1:0]  bresp,
	output      logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output      logic        arready,
	output      logic [31:0] rdata,
	output      logic [1:0]  rresp,
	output      logic        rvalid,
	input  wire logic        rready,
	input  wire logic        external_count_pin,
	input  wire logic        capture_input_pin,
	input  wire logic        comparator_output,
	output      logic        compare_output_a,
	output      logic        compare_output_b,
	output      logic [3:0]  irq_request
);
	// ************************************************************
	// state
	// ************************************************************
	t16_byte_t  timer_control_a;
	t16_byte_t  timer_control_b;
	t16_byte_t  timer_irq_flags;
	t16_byte_t  timer_irq_mask;
	t16_byte_t  hold;
	t16_word_t  counter_value;
	t16_word_t  compare_value_a;
	t16_word_t  compare_value_b;
	t16_word_t  cmp_buf_a;
	t16_word_t  cmp_buf_b;
	t16_word_t  capture_value;
	logic [PRE_W-1:0] pre;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin_ok;
	logic [`T16_FILTER_LEN-1:0] fsh;
	logic       filt;
	logic       cap_in_q;
	logic       ext_q;
	logic       tick_q;
	t16_ctl_s   ctl;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire        wr_go   = awready & awvalid & wready & wvalid;
	wire        rd_go   = arready & arvalid;
	wire        wr_en   = wr_go & wstrb[0];
	wire [7:0]  wb      = wdata[7:0];
	wire        wr_ctla = wr_en & (awaddr == `T16_OFS_CTL_A);
	wire        wr_ctlb = wr_en & (awaddr == `T16_OFS_CTL_B);
	wire        wr_cnt  = wr_en & (awaddr == `T16_OFS_CNT_LO);
	wire        wr_cmpa = wr_en & (awaddr == `T16_OFS_CMPA_LO);
	wire        wr_cmpb = wr_en & (awaddr == `T16_OFS_CMPB_LO);
	wire        wr_cap  = wr_en & (awaddr == `T16_OFS_CAP_LO);
	wire        wr_flg  = wr_en & (awaddr == `T16_OFS_FLAGS);
	wire        wr_msk  = wr_en & (awaddr == `T16_OFS_MASK);
	wire        wr_hi   = wr_en & ((awaddr == `T16_OFS_CNT_HI) | (awaddr == `T16_OFS_CMPA_HI) |
				(awaddr == `T16_OFS_CMPB_HI) | (awaddr == `T16_OFS_CAP_HI));
	wire        rd_cnt  = rd_go & (araddr == `T16_OFS_CNT_LO);
	wire        rd_cap  = rd_go & (araddr == `T16_OFS_CAP_LO);
	wire        aw_map  = (awaddr[1:0] == 2'b00) & (awaddr <= `T16_OFS_MASK);
	wire        ar_map  = (araddr[1:0] == 2'b00) & (araddr <= `T16_OFS_MASK);
	wire [15:0] wr_word = {hold, wb};

	// ************************************************************
	// mode and limit
	// ************************************************************
	// force bits in A, mode bit3 in B
	assign ctl.wave_mode = {timer_control_b[`T16_B_WAVE3], timer_control_b[`T16_B_WAVE2],
				timer_control_a[`T16_A_WAVE1], timer_control_a[`T16_A_WAVE0]};
	assign ctl.tick_source_select = t16_tick_e'(timer_control_b[2:0]);
	assign ctl.capture_edge_rise = timer_control_b[`T16_B_CAP_EDGE];
	assign ctl.capture_filter_enable = timer_control_b[`T16_B_FILTER];
	assign ctl.capture_from_comparator = timer_control_a[`T16_A_CAP_SRC];

	wire [3:0] wm = ctl.wave_mode;
	wire top_is_a = (wm == 4'h4) | (wm == 4'h9) | (wm == 4'hb) | (wm == 4'hf);
	wire top_is_cap = (wm == 4'h8) | (wm == 4'ha) | (wm == 4'hc) | (wm == 4'he);
	wire pwm_mode = ~((wm == 4'h0) | (wm == 4'h4) | (wm == 4'hc));
	wire [15:0] top = top_is_a ? compare_value_a :
			top_is_cap ? capture_value :
			(wm[1:0] == 2'h1) ? `T16_TOP_8BIT :
			(wm[1:0] == 2'h2) ? `T16_TOP_9BIT :
			(wm[1:0] == 2'h3) ? `T16_TOP_10BIT : `T16_MAX;
	wire at_top = (counter_value == top);
	wire at_bottom = (counter_value == `T16_BOTTOM);
	wire at_max = (counter_value == `T16_MAX);

	// ************************************************************
	// pin synchronisers and tick
	// ************************************************************
	wire [2:0] pins = {comparator_output, capture_input_pin, external_count_pin};
	// a change is believed only once the last two stages agree
	wire [2:0] next_pin_ok = (sync2 & sync3) | (pin_ok & (sync2 | sync3));
	wire ext_rise = pin_ok[0] & ~ext_q;
	wire ext_fall = ~pin_ok[0] & ext_q;
	wire [PRE_W-1:0] ones = {PRE_W{1'b1}};
	wire tick = (ctl.tick_source_select == T16_TICK_DIV1) |
		((ctl.tick_source_select == T16_TICK_DIV8) & (pre[2:0] == ones[2:0])) |
		((ctl.tick_source_select == T16_TICK_DIV64) & (pre[5:0] == ones[5:0])) |
		((ctl.tick_source_select == T16_TICK_DIV256) & (pre[7:0] == ones[7:0])) |
		((ctl.tick_source_select == T16_TICK_DIV1K) & (pre == ones)) |
		((ctl.tick_source_select == T16_TICK_EXTF) & ext_fall) |
		((ctl.tick_source_select == T16_TICK_EXTR) & ext_rise);
	wire upd = tick & at_top & ~wr_cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1  <= 3'h0;
			sync2  <= 3'h0;
			sync3  <= 3'h0;
			pin_ok <= 3'h0;
			ext_q  <= 1'b0;
			pre    <= '0;
			tick_q <= 1'b0;
		end else begin
			sync1  <= pins;
			sync2  <= sync1;
			sync3  <= sync2;
			pin_ok <= next_pin_ok;
			ext_q  <= pin_ok[0];
			pre    <= pre + 1'b1;
			tick_q <= tick & ~wr_cnt;
		end
	end

	// ************************************************************
	// counter
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter_value <= `T16_RST_WORD;
		end else if (wr_cnt) begin
			counter_value <= wr_word;
		end else if (tick) begin
			counter_value <= at_top ? `T16_BOTTOM : counter_value + 16'h0001;
		end
	end

	// ************************************************************
	// compare units
	// ************************************************************
	// continuous equality
	wire match_a = (counter_value == compare_value_a);
	wire match_b = (counter_value == compare_value_b);
	wire evt_a   = match_a & tick_q;
	wire evt_b   = match_b & tick_q;
	wire force_a = wr_ctla & wb[`T16_A_FORCE_A] & ~pwm_mode;
	wire force_b = wr_ctla & wb[`T16_A_FORCE_B] & ~pwm_mode;
	wire pwm_set = pwm_mode & tick_q & at_bottom;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_buf_a       <= `T16_RST_WORD;
			cmp_buf_b       <= `T16_RST_WORD;
			compare_value_a <= `T16_RST_WORD;
			compare_value_b <= `T16_RST_WORD;
		end else begin
			if (wr_cmpa)
				cmp_buf_a <= wr_word;
			if (wr_cmpb)
				cmp_buf_b <= wr_word;
			// buffered limit loads at the top
			if (wr_cmpa & ~pwm_mode)
				compare_value_a <= wr_word;
			else if (pwm_mode & upd)
				compare_value_a <= cmp_buf_a;
			if (wr_cmpb & ~pwm_mode)
				compare_value_b <= wr_word;
			else if (pwm_mode & upd)
				compare_value_b <= cmp_buf_b;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_output_a <= 1'b0;
			compare_output_b <= 1'b0;
		end else begin
			// no PWM on A when A is the limit
			if (pwm_mode & top_is_a)
				compare_output_a <= 1'b0;
			else if (pwm_mode)
				compare_output_a <= evt_a ? 1'b0 : (pwm_set | compare_output_a);
			else if (evt_a | force_a)
				compare_output_a <= ~compare_output_a;
			if (pwm_mode)
				compare_output_b <= evt_b ? 1'b0 : (pwm_set | compare_output_b);
			else if (evt_b | force_b)
				compare_output_b <= ~compare_output_b;
		end
	end

	// ************************************************************
	// capture unit
	// ************************************************************
	wire cap_raw  = ctl.capture_from_comparator ? pin_ok[2] : pin_ok[1];
	wire fsh_same = (fsh == {`T16_FILTER_LEN{1'b1}}) | (fsh == {`T16_FILTER_LEN{1'b0}});
	wire cap_in   = ctl.capture_filter_enable ? filt : cap_raw;
	wire cap_evt  = ~top_is_cap & (ctl.capture_edge_rise ? (cap_in & ~cap_in_q) :
			(~cap_in & cap_in_q));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fsh           <= '0;
			filt          <= 1'b0;
			cap_in_q      <= 1'b0;
			capture_value <= `T16_RST_WORD;
		end else begin
			fsh      <= {fsh[`T16_FILTER_LEN-2:0], cap_raw};
			filt     <= fsh_same ? fsh[0] : filt;
			cap_in_q <= cap_in;
			if (cap_evt)
				capture_value <= counter_value;
			else if (wr_cap & top_is_cap)
				capture_value <= wr_word;
		end
	end

	// ************************************************************
	// holding register, flags, controls
	// ************************************************************
	// request flags; a hardware set wins over a clear
	wire [3:0] flg_set = {cap_evt, evt_a, evt_b, upd & (at_max | pwm_mode | top_is_a | top_is_cap)};
	wire [3:0] flg_clr = wr_flg ? wb[3:0] : 4'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold            <= `T16_RST_BYTE;
			timer_control_a <= `T16_RST_BYTE;
			timer_control_b <= `T16_RST_BYTE;
			timer_irq_flags <= `T16_RST_BYTE;
			timer_irq_mask  <= `T16_RST_BYTE;
			irq_request     <= 4'h0;
		end else begin
			// single holding byte; kept across low writes
			if (wr_hi)
				hold <= wb;
			else if (rd_cnt)
				hold <= counter_value[15:8];
			else if (rd_cap)
				hold <= capture_value[15:8];
			// plain 8-bit controls, force bits not stored
			if (wr_ctla)
				timer_control_a <= wb & 8'h13;
			if (wr_ctlb)
				timer_control_b <= wb & 8'hdf;
			timer_irq_flags <= {4'h0, (timer_irq_flags[3:0] & ~flg_clr) | flg_set};
			if (wr_msk)
				timer_irq_mask <= {4'h0, wb[3:0]};
			irq_request <= timer_irq_flags[3:0] & timer_irq_mask[3:0];
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic [7:0] rd_byte;
	always_comb begin
		case (araddr)
			`T16_OFS_CTL_A:   rd_byte = timer_control_a;
			`T16_OFS_CTL_B:   rd_byte = timer_control_b;
			`T16_OFS_CNT_LO:  rd_byte = counter_value[7:0];
			`T16_OFS_CAP_LO:  rd_byte = capture_value[7:0];
			`T16_OFS_CMPA_LO: rd_byte = cmp_buf_a[7:0];
			`T16_OFS_CMPA_HI: rd_byte = cmp_buf_a[15:8];
			`T16_OFS_CMPB_LO: rd_byte = cmp_buf_b[7:0];
			`T16_OFS_CMPB_HI: rd_byte = cmp_buf_b[15:8];
			`T16_OFS_CNT_HI:  rd_byte = hold;
			`T16_OFS_CAP_HI:  rd_byte = hold;
			`T16_OFS_FLAGS:   rd_byte = timer_irq_flags;
			`T16_OFS_MASK:    rd_byte = timer_irq_mask;
			default:          rd_byte = 8'h00;
		endcase
	end

	// address and data are only taken together, so neither can run ahead
	wire aw_take = awvalid & wvalid & ~awready & ~bvalid;
	wire ar_take = arvalid & ~arready & ~rvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `T16_RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `T16_RESP_OKAY;
		end else begin
			awready <= aw_take;
			wready  <= aw_take;
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= aw_map ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			arready <= ar_take;
			if (rd_go) begin
				rvalid <= 1'b1;
				rdata  <= {24'h00_0000, rd_byte};
				rresp  <= ar_map ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	t16_word_t last_wr;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			last_wr <= `T16_RST_WORD;
		else
			last_wr <= wr_word;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_IDLE: assert property (
		(ctl.tick_source_select == T16_TICK_NONE && !wr_cnt) |=> $stable(counter_value))
		else $error("counter moved with no tick source");
	AST_WRITE: assert property (
		wr_cnt |=> counter_value == last_wr) else $error("low write did not load word");
	AST_WR_PRIO: assert property (
		(wr_cnt && tick) |=> counter_value == last_wr) else $error("count beat a write");
	AST_WRAP: assert property (
		(tick && at_top && !wr_cnt) |=> at_bottom) else $error("no wrap at limit");
	AST_RD_COPY: assert property (
		(rd_cnt && !wr_hi) |=> hold == $past(counter_value[15:8]))
		else $error("low read did not copy high byte");
	AST_RD_HI: assert property (
		(rd_go && araddr == `T16_OFS_CNT_HI) |=> rdata[7:0] == $past(hold))
		else $error("high read not from holding byte");
	AST_CMP_RD: assert property (
		(rd_go && araddr == `T16_OFS_CMPA_LO && !wr_hi) |=> $stable(hold))
		else $error("compare read touched holding byte");
	AST_MATCH: assert property (
		evt_a |=> timer_irq_flags[`T16_F_MATCH_A]) else $error("match flag not set");
	AST_CAPTURE: assert property (
		cap_evt |=> capture_value == $past(counter_value) ##1 irq_request[`T16_F_CAPTURE]
		== timer_irq_mask[`T16_F_CAPTURE]) else $error("capture missed counter or request");
	AST_FILTER: assert property (
		$changed(filt) |-> $past(fsh_same)) else $error("filter changed early");
	AST_NO_PWM_A: assert property (
		(pwm_mode && top_is_a) [*2] |-> !compare_output_a) else $error("pwm on limit unit");

	COV_WRITE: cover property (wr_cnt ##[1:20] rd_cnt);
	COV_CAPTURE: cover property (cap_evt ##1 rd_cap);
	COV_MATCH: cover property (evt_a ##[1:50] evt_b);
endmodule

// file: bench/t16_cpu.sv
// t16_cpu.sv: register bus master standing in for the cpu on the timer's byte bus.
// assumes: shares clk with the timer; one caller at a time, entering right after an edge.
`timescale 1ns/1ps
module t16_cpu (
	input  wire logic        clk,
	output      logic [7:0]  awaddr,
	output      logic        awvalid,
	input  wire logic        awready,
	output      logic [31:0] wdata,
	output      logic [3:0]  wstrb,
	output      logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output      logic        bready,
	output      logic [7:0]  araddr,
	output      logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output      logic        rready
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wstrb} = 20'h00000;
		wdata = 32'h00000000;
	end

	// released payload is inverted so a stale value is never mistaken for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		bit got_aw;
		bit got_w;
		got_aw = 1'b0;
		got_w = 1'b0;
		{awaddr, wdata, wstrb} <= {a, 24'h000000, d, 4'h1};
		{awvalid, wvalid, bready} <= 3'b111;
		while (!(got_aw && got_w)) begin
			@(posedge clk);
			if (awready === 1'b1) begin
				got_aw = 1'b1;
				{awvalid, awaddr} <= {1'b0, ~a};
			end
			if (wready === 1'b1) begin
				got_w = 1'b1;
				{wvalid, wdata} <= {1'b0, ~wdata};
			end
		end
		do begin
			@(posedge clk);
		end while (bvalid !== 1'b1);
		// bready stays up between writes so it is never lowered and raised in one step
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do begin
			@(posedge clk);
		end while (arready !== 1'b1);
		{arvalid, araddr} <= {1'b0, ~a};
		do begin
			@(posedge clk);
		end while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
	endtask

	task automatic w16(input logic [7:0] lo, input logic [15:0] v, output logic [1:0] r);
		logic [1:0] rh;
		wr(lo + 8'h04, v[15:8], rh);
		wr(lo, v[7:0], r);
		r = r | rh;
	endtask

	task automatic r16(input logic [7:0] lo, output logic [15:0] v, output logic [1:0] r);
		logic [1:0] rl;
		rd(lo, v[7:0], rl);
		rd(lo + 8'h04, v[15:8], r);
		r = r | rl;
	endtask
endmodule

// file: bench/testbench.sv
// testbench.sv: self-checking bench for the 16-bit timer with byte access.
// assumes: t16_core and the cpu model t16_cpu compiled first.
`timescale 1ns/1ps
`include "t16_map.svh"
module testbench;
	logic        clk;
	logic        rst;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [3:0]  irq_request;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        external_count_pin, capture_input_pin, comparator_output;
	logic        compare_output_a, compare_output_b;
	int          failures;
	int          n_compared;

	always #12.5 clk = ~clk;

	t16_core #(.PRE_W(10)) i_dut (
		.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .external_count_pin, .capture_input_pin, .comparator_output,
		.compare_output_a, .compare_output_b, .irq_request
	);
	t16_cpu i_cpu (
		.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);

	// ************************************************************
	// shared helpers
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		i_cpu.wr(a, d, r);
		chk(r, `T16_RESP_OKAY, "write resp");
	endtask
	task automatic w16(input logic [7:0] lo, input logic [15:0] v);
		logic [1:0] r;
		i_cpu.w16(lo, v, r);
		chk(r, `T16_RESP_OKAY, "write16 resp");
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
		logic [7:0] d;
		logic [1:0] r;
		i_cpu.rd(a, d, r);
		chk(r, `T16_RESP_OKAY, "read resp");
		chk(d, e, what);
	endtask
	task automatic r16chk(input logic [7:0] lo, input logic [15:0] e, input string what);
		logic [15:0] v;
		logic [1:0]  r;
		i_cpu.r16(lo, v, r);
		chk(v, e, what);
	endtask
	// a short burst of ticks: start then stop at bus speed
	task automatic run(input logic [7:0] mb);
		w(`T16_OFS_CTL_B, mb | 8'h01);
		w(`T16_OFS_CTL_B, mb);
	endtask
	task automatic pulse(input bit cmp, input int width);
		if (cmp) comparator_output <= 1'b1;
		else capture_input_pin <= 1'b1;
		repeat (width) @(posedge clk);
		{comparator_output, capture_input_pin} <= 2'b00;
		repeat (12) @(posedge clk);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		rchk(`T16_OFS_CNT_HI, 8'h00, "hold after reset");
		rchk(`T16_OFS_FLAGS, 8'h00, "flags after reset");
		w(`T16_OFS_CTL_A, 8'h1f);
		rchk(`T16_OFS_CTL_A, 8'h13, "ctl a");
		w(`T16_OFS_CTL_B, 8'hf8);
		rchk(`T16_OFS_CTL_B, 8'hd8, "ctl b");
		w(`T16_OFS_CTL_B, 8'h00);
		w(`T16_OFS_CTL_A, 8'h00);
	endtask
	task automatic t_word();
		w16(`T16_OFS_CNT_LO, 16'h01ff);
		r16chk(`T16_OFS_CNT_LO, 16'h01ff, "cnt");
		r16chk(`T16_OFS_CNT_LO, 16'h01ff, "cnt idle");
		w(`T16_OFS_CNT_HI, 8'h55);
		rchk(`T16_OFS_CNT_HI, 8'h55, "hi from hold");
		w(`T16_OFS_CMPA_HI, 8'h12);
		w(`T16_OFS_CMPA_LO, 8'h34);
		w(`T16_OFS_CMPB_LO, 8'h56);
		rchk(`T16_OFS_CMPB_HI, 8'h12, "cmpb hi");
		rchk(`T16_OFS_CNT_LO, 8'hff, "cnt lo");
		rchk(`T16_OFS_CMPA_LO, 8'h34, "cmpa lo");
		rchk(`T16_OFS_CMPA_HI, 8'h12, "cmpa hi direct");
		rchk(`T16_OFS_CNT_HI, 8'h01, "hold kept");
	endtask
	task automatic t_match();
		logic oa;
		logic ob;
		w16(`T16_OFS_CNT_LO, 16'h0100);
		w16(`T16_OFS_CMPA_LO, 16'h0102);
		w16(`T16_OFS_CMPB_LO, 16'h0f00);
		w(`T16_OFS_MASK, 8'h00);
		w(`T16_OFS_FLAGS, 8'h0f);
		{oa, ob} = {compare_output_a, compare_output_b};
		run(8'h00);
		chk(compare_output_a, {31'h0, ~oa}, "match toggles output a");
		chk(compare_output_b, {31'h0, ob}, "output b held");
		rchk(`T16_OFS_FLAGS, 8'h04, "match a only");
		chk(irq_request, 4'h0, "masked irq");
		w(`T16_OFS_MASK, 8'h04);
		repeat (2) @(posedge clk);
		chk(irq_request, 4'h4, "unmasked irq");
		w(`T16_OFS_FLAGS, 8'h04);
		repeat (2) @(posedge clk);
		chk(irq_request, 4'h0, "cleared irq");
		rchk(`T16_OFS_FLAGS, 8'h00, "flag cleared");
	endtask
	// modes 0..3 fixed limits, 4 limit from compare a, 12 limit from capture
	task automatic t_limit();
		logic [7:0]  ma [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00};
		logic [7:0]  mb [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h18};
		logic [15:0] top [6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0020, 16'h0030};
		logic [15:0] v;
		logic [1:0]  r;
		for (int i = 0; i < 6; i++) begin
			w(`T16_OFS_CTL_A, ma[i]);
			w(`T16_OFS_CTL_B, mb[i]);
			if (i == 4) w16(`T16_OFS_CMPA_LO, top[i]);
			if (i == 5) w16(`T16_OFS_CAP_LO, top[i]);
			w16(`T16_OFS_CNT_LO, top[i] - 16'h0001);
			w(`T16_OFS_FLAGS, 8'h0f);
			run(mb[i]);
			i_cpu.r16(`T16_OFS_CNT_LO, v, r);
			chk({31'h0, v < 16'h0010}, 32'h1, "wrapped at limit");
			i_cpu.rd(`T16_OFS_FLAGS, v[7:0], r);
			chk(v[0], 1'b1, "overflow flag");
		end
		w(`T16_OFS_CTL_B, 8'h00);
		w(`T16_OFS_CTL_A, 8'h00);
	endtask
	task automatic t_ext();
		int          dv [4] = '{8, 64, 256, 1024};
		logic [15:0] v;
		logic [1:0]  r;
		for (int s = 6; s < 8; s++) begin
			w16(`T16_OFS_CNT_LO, 16'h0000);
			w(`T16_OFS_CTL_B, 8'(s));
			repeat (3) begin
				external_count_pin <= 1'b1;
				repeat (6) @(posedge clk);
				external_count_pin <= 1'b0;
				repeat (6) @(posedge clk);
			end
			w(`T16_OFS_CTL_B, 8'h00);
			r16chk(`T16_OFS_CNT_LO, 16'h0003, "external edges");
		end
		w16(`T16_OFS_CNT_LO, 16'h0000);
		// prescaled taps: twice the divisor plus bus latency gives two or three ticks
		for (int s = 2; s < 6; s++) begin
			w16(`T16_OFS_CNT_LO, 16'h0000);
			w(`T16_OFS_CTL_B, 8'(s));
			repeat (2 * dv[s-2]) @(posedge clk);
			w(`T16_OFS_CTL_B, 8'h00);
			i_cpu.r16(`T16_OFS_CNT_LO, v, r);
			chk({31'h0, (v == 16'h0002) || (v == 16'h0003)}, 32'h1, "prescaled ticks");
		end
		w(`T16_OFS_CTL_B, 8'h01);
		w16(`T16_OFS_CNT_LO, 16'h4000);
		w(`T16_OFS_CTL_B, 8'h00);
		// three ticks land after the write: two bus cycles of the stop write plus its handshake
		rchk(`T16_OFS_CNT_LO, 8'h03, "cnt lo");
		rchk(`T16_OFS_CNT_HI, 8'h40, "write beats count");
	endtask
	task automatic t_capture();
		w16(`T16_OFS_CNT_LO, 16'h1234);
		w(`T16_OFS_CTL_B, 8'h40);
		w(`T16_OFS_FLAGS, 8'h0f);
		pulse(1'b0, 3);
		rchk(`T16_OFS_FLAGS, 8'h08, "capture flag");
		r16chk(`T16_OFS_CAP_LO, 16'h1234, "capture pin");
		w(`T16_OFS_CTL_A, 8'h10);
		w16(`T16_OFS_CNT_LO, 16'h0abc);
		w(`T16_OFS_FLAGS, 8'h0f);
		pulse(1'b1, 3);
		r16chk(`T16_OFS_CAP_LO, 16'h0abc, "capture comparator");
		w(`T16_OFS_CTL_A, 8'h00);
		w(`T16_OFS_CTL_B, 8'hc0);
		w16(`T16_OFS_CNT_LO, 16'h2222);
		w(`T16_OFS_FLAGS, 8'h0f);
		pulse(1'b0, 2);
		rchk(`T16_OFS_FLAGS, 8'h00, "glitch filtered");
		pulse(1'b0, 8);
		r16chk(`T16_OFS_CAP_LO, 16'h2222, "filtered capture");
		w(`T16_OFS_CTL_B, 8'h00);
	endtask
	task automatic t_bus();
		logic [7:0] d;
		logic [1:0] r;
		i_cpu.wr(8'h30, 8'h00, r);
		chk(r, `T16_RESP_SLVERR, "unmapped write");
		i_cpu.rd(8'h30, d, r);
		chk(r, `T16_RESP_SLVERR, "unmapped read");
		i_cpu.rd(8'h02, d, r);
		chk(r, `T16_RESP_SLVERR, "unaligned read");
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// whole run is a few thousand cycles; this allows ten times that
	initial begin
		#(25 * 40000);
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{external_count_pin, capture_input_pin, comparator_output} = 3'b000;
		failures = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_word();
		t_match();
		t_limit();
		t_ext();
		t_capture();
		t_bus();
		end_sim();
	end
endmodule
